// ### rtl/spi_port_params.svh
// spi_port_params.svh - offsets, field positions and reset values for the serial port
// assumes a byte-wide register port with word-aligned byte addresses
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// register byte addresses
`define SPI_ADDR_W          8
`define SPI_OFS_CONTROL     8'h00
`define SPI_OFS_DATA        8'h04
`define SPI_OFS_CLKDIV      8'h08

// control register field positions
`define SPI_CTL_DONE        7
`define SPI_CTL_MST_EN      6
`define SPI_CTL_FAULT       5
`define SPI_CTL_TX_FULL     4
`define SPI_CTL_MODE_HI     3
`define SPI_CTL_MODE_LO     2
`define SPI_CTL_BUSY        1
`define SPI_CTL_PORT_EN     0

// select mode encodings
`define SPI_MODE_3WIRE      2'h0
`define SPI_MODE_NSS_IN     2'h1

// reset values and last bit index
`define SPI_CLKDIV_RESET    8'h03
`define SPI_BYTE_RESET      8'h00
`define SPI_LAST_BIT        3'h7

`endif

// ### rtl/spi_port_pkg.sv
// spi_port_pkg.sv - types shared by the serial port design
// assumes spi_port_params.svh provides the numeric constants
package spi_port_pkg;

   // master shifter phase
   typedef enum logic [0:0] {
      PH_IDLE,
      PH_SHIFT
   } phase_t;

   // software-visible control bits
   typedef struct packed {
      logic       done;
      logic       mst_en;
      logic       fault;
      logic [1:0] mode;
      logic       port_en;
   } ctrl_t;

   // synchronised pin levels: sck, mosi, miso, nss
   typedef struct packed {
      logic sck;
      logic mosi;
      logic miso;
      logic nss;
   } pins_t;

   // every flip-flop of the port
   typedef struct packed {
      ctrl_t      ctrl;
      logic [7:0] clkdiv;
      logic [7:0] txbuf;
      logic       tx_full;
      logic [7:0] rxbuf;
      logic [7:0] shreg;
      logic [2:0] bitcnt;
      phase_t     phase;
      logic [7:0] divcnt;
      logic       sck;
      logic       sampled;
      logic       slave_loaded;
      logic [7:0] rdata;
      pins_t      sync1;
      pins_t      sync2;
      logic       sck_prev;
      logic       nss_prev;
   } state_t;

endpackage

// ### rtl/spi_port.sv
// spi_port.sv - full-duplex serial port, master or slave, three- or four-line
// assumes pins arrive asynchronous to clk_in; the pad logic resolves each pin from its enable
`timescale 1ns/1ps
`include "spi_port_params.svh"

// Operation
// - full-duplex byte transfers as master or slave, three- or four-line, shared bus
// - mosi is driven when master, an input when slave
// - miso is an input when master, driven when slave
// - both data lines carry the most significant bit first
// - as master, mosi comes from the shifter's top bit
// - miso released when port disabled or four-line slave not selected
// - three-line slave always drives miso from the shifter's top bit
// - master generates the serial clock
// - four-line slave in select mode 01 with select high ignores the serial clock
// - select mode 00: three-line, select unused, slave always selected
// - select mode 01: four-line, select pin is an input choosing the slave
// - mode 01 master: falling select input turns master function off
// - select mode 1x: four-line, select pin driven with the low mode bit
// - select pin routed to a pad in every mode except three-line
// - setting control bit 6 enters master mode
// - master data register writes go to the transmit buffer
// - full buffer and empty shifter: byte moves over and transfer starts
// - master transfer puts the top bit on mosi at once, before the first clock rise
module spi_port (
   input  wire logic                   clk_in,
   input  wire logic                   srst_in,
   input  wire logic [`SPI_ADDR_W-1:0] addr_in,
   input  wire logic [7:0]             wdata_in,
   input  wire logic                   wr_in,
   input  wire logic                   rd_in,
   output logic      [7:0]             rdata_out,
   input  wire logic                   sck_in,
   output logic                        sck_out,
   output logic                        sck_oe_out,
   input  wire logic                   mosi_in,
   output logic                        mosi_out,
   output logic                        mosi_oe_out,
   input  wire logic                   miso_in,
   output logic                        miso_out,
   output logic                        miso_oe_out,
   input  wire logic                   nss_in,
   output logic                        nss_out,
   output logic                        nss_oe_out,
   output logic                        nss_routed_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state and helpers

   spi_port_pkg::state_t st;
   spi_port_pkg::state_t next_st;

   logic is_master;
   logic is_slave;
   logic selected;
   logic sck_rise;
   logic nss_fall;
   logic mode_fault;
   logic wr_ctrl;
   logic wr_data;

   // shift one bit in at the bottom, top bit leaves first
   function automatic logic [7:0] shift_in(input logic [7:0] value, input logic bit_in);
      shift_in = {value[6:0], bit_in};
   endfunction

   // control register as software reads it
   function automatic logic [7:0] ctrl_view(input spi_port_pkg::state_t s);
      logic [7:0] v;
      v                     = 8'h00;
      v[`SPI_CTL_DONE]      = s.ctrl.done;
      v[`SPI_CTL_MST_EN]    = s.ctrl.mst_en;
      v[`SPI_CTL_FAULT]     = s.ctrl.fault;
      v[`SPI_CTL_TX_FULL]   = s.tx_full;
      v[`SPI_CTL_MODE_HI]   = s.ctrl.mode[1];
      v[`SPI_CTL_MODE_LO]   = s.ctrl.mode[0];
      v[`SPI_CTL_BUSY]      = (s.phase == spi_port_pkg::PH_SHIFT);
      v[`SPI_CTL_PORT_EN]   = s.ctrl.port_en;
      ctrl_view             = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // decode of role, selection and pin events

   assign is_master = st.ctrl.port_en & st.ctrl.mst_en;
   assign is_slave  = st.ctrl.port_en & ~st.ctrl.mst_en;
   // only select mode 01 reads the pin; other modes count as selected
   assign selected  = (st.ctrl.mode != `SPI_MODE_NSS_IN) | ~st.sync2.nss;
   assign sck_rise  = st.sync2.sck & ~st.sck_prev;
   assign nss_fall  = st.nss_prev & ~st.sync2.nss;
   assign mode_fault = is_master & (st.ctrl.mode == `SPI_MODE_NSS_IN) & nss_fall;
   assign wr_ctrl   = wr_in & (addr_in == `SPI_OFS_CONTROL);
   assign wr_data   = wr_in & (addr_in == `SPI_OFS_DATA);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // pin drivers

   assign sck_out        = st.sck;
   assign sck_oe_out     = is_master;
   assign mosi_out       = st.shreg[7];
   assign mosi_oe_out    = is_master;
   assign miso_out       = st.shreg[7];
   assign miso_oe_out    = is_slave & selected;
   assign nss_out        = st.ctrl.mode[0];
   assign nss_oe_out     = st.ctrl.port_en & st.ctrl.mode[1];
   assign nss_routed_out = (st.ctrl.mode != `SPI_MODE_3WIRE);
   assign rdata_out      = st.rdata;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      logic       set_done;
      logic [7:0] rx_byte;
      next_st  = st;
      set_done = 1'b0;
      rx_byte  = st.shreg;

      // two-flop synchronisers, first stage feeds the second only
      next_st.sync1    = {sck_in, mosi_in, miso_in, nss_in};
      next_st.sync2    = st.sync1;
      next_st.sck_prev = st.sync2.sck;
      next_st.nss_prev = st.sync2.nss;

      // master side: buffer to shifter, then eight clock periods
      if (is_master) begin
         next_st.slave_loaded = 1'b0;
         unique case (st.phase)
            spi_port_pkg::PH_IDLE: begin
               next_st.sck    = 1'b0;
               next_st.divcnt = 8'h00;
               if (st.tx_full) begin
                  next_st.shreg   = st.txbuf;
                  next_st.tx_full = 1'b0;
                  next_st.bitcnt  = 3'h0;
                  next_st.phase   = spi_port_pkg::PH_SHIFT;
               end
            end
            spi_port_pkg::PH_SHIFT: begin
               if (st.divcnt == st.clkdiv) begin
                  next_st.divcnt = 8'h00;
                  next_st.sck    = ~st.sck;
                  if (!st.sck) begin
                     next_st.sampled = st.sync2.miso;
                  end else begin
                     next_st.shreg  = shift_in(st.shreg, st.sampled);
                     next_st.bitcnt = st.bitcnt + 3'h1;
                     if (st.bitcnt == `SPI_LAST_BIT) begin
                        rx_byte       = shift_in(st.shreg, st.sampled);
                        next_st.rxbuf = rx_byte;
                        set_done      = 1'b1;
                        next_st.phase = spi_port_pkg::PH_IDLE;
                     end
                  end
               end else begin
                  next_st.divcnt = st.divcnt + 8'h01;
               end
            end
         endcase
      end else begin
         next_st.phase  = spi_port_pkg::PH_IDLE;
         next_st.sck    = 1'b0;
         next_st.divcnt = 8'h00;
      end

      // slave side: clock taken only while selected
      if (is_slave) begin
         if (!selected) begin
            next_st.bitcnt       = 3'h0;
            next_st.slave_loaded = 1'b0;
         end else begin
            if (!st.slave_loaded && st.bitcnt == 3'h0 && st.tx_full) begin
               next_st.shreg        = st.txbuf;
               next_st.tx_full      = 1'b0;
               next_st.slave_loaded = 1'b1;
            end else if (sck_rise) begin
               next_st.shreg  = shift_in(st.shreg, st.sync2.mosi);
               next_st.bitcnt = st.bitcnt + 3'h1;
               if (st.bitcnt == `SPI_LAST_BIT) begin
                  next_st.rxbuf        = shift_in(st.shreg, st.sync2.mosi);
                  set_done             = 1'b1;
                  next_st.slave_loaded = 1'b0;
               end
            end
         end
      end

      // register writes
      if (wr_ctrl) begin
         next_st.ctrl.mst_en  = wdata_in[`SPI_CTL_MST_EN];
         next_st.ctrl.mode    = wdata_in[`SPI_CTL_MODE_HI:`SPI_CTL_MODE_LO];
         next_st.ctrl.port_en = wdata_in[`SPI_CTL_PORT_EN];
         next_st.ctrl.done    = st.ctrl.done & wdata_in[`SPI_CTL_DONE];
         next_st.ctrl.fault   = st.ctrl.fault & wdata_in[`SPI_CTL_FAULT];
      end
      if (wr_data) begin
         next_st.txbuf   = wdata_in;
         next_st.tx_full = 1'b1;
      end
      if (wr_in && addr_in == `SPI_OFS_CLKDIV) begin
         next_st.clkdiv = wdata_in;
      end

      // hardware events win over software clears
      if (set_done) begin
         next_st.ctrl.done = 1'b1;
      end
      if (mode_fault) begin
         next_st.ctrl.mst_en = 1'b0;
         next_st.ctrl.fault  = 1'b1;
         next_st.phase       = spi_port_pkg::PH_IDLE;
         next_st.sck         = 1'b0;
      end

      // read data one cycle after the strobe, zero elsewhere
      next_st.rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            `SPI_OFS_CONTROL: next_st.rdata = ctrl_view(st);
            `SPI_OFS_DATA:    next_st.rdata = st.rxbuf;
            `SPI_OFS_CLKDIV:  next_st.rdata = st.clkdiv;
            default:          next_st.rdata = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state register

   // reset image of the state; edge detectors and synchronisers start low
   function automatic spi_port_pkg::state_t reset_image();
      spi_port_pkg::state_t r;
      r           = '0;
      r.clkdiv    = `SPI_CLKDIV_RESET;
      r.txbuf     = `SPI_BYTE_RESET;
      r.rxbuf     = `SPI_BYTE_RESET;
      r.shreg     = `SPI_BYTE_RESET;
      r.phase     = spi_port_pkg::PH_IDLE;
      reset_image = r;
   endfunction

   // one register stage holds every flip-flop; reset loads constants only
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         st <= reset_image();
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   a_mosi_dir: assert property (mosi_oe_out == (st.ctrl.port_en && st.ctrl.mst_en))
      else $error("mosi enable does not follow master role");

   a_miso_release: assert property (!st.ctrl.port_en || st.ctrl.mst_en |-> !miso_oe_out)
      else $error("miso driven while disabled or master");

   a_miso_unsel: assert property (is_slave && st.ctrl.mode == 2'h1 && st.sync2.nss
                                  |-> !miso_oe_out)
      else $error("miso driven by unselected four-line slave");

   a_slave_3wire: assert property (is_slave && st.ctrl.mode == 2'h0
                                   |-> miso_oe_out && miso_out == st.shreg[7])
      else $error("three-line slave not driving miso");

   a_sck_ignore: assert property (is_slave && st.ctrl.mode == 2'h1 && st.sync2.nss && !wr_ctrl
                                  |=> st.bitcnt == 3'h0)
      else $error("unselected slave counted clock edges");

   a_fault_off: assert property (mode_fault |=> !st.ctrl.mst_en && st.ctrl.fault
                                 && st.phase == spi_port_pkg::PH_IDLE)
      else $error("select fall did not stop the master");

   a_nss_drive: assert property (st.ctrl.port_en && st.ctrl.mode[1]
                                 |-> nss_oe_out && nss_out == st.ctrl.mode[0])
      else $error("select output level wrong");

   a_nss_route: assert property (nss_routed_out == (st.ctrl.mode != 2'h0))
      else $error("select routing wrong");

   a_start_xfer: assert property (is_master && st.phase == spi_port_pkg::PH_IDLE && st.tx_full
                                  && !mode_fault |=> st.phase == spi_port_pkg::PH_SHIFT
                                  && mosi_out == $past(st.txbuf[7]))
      else $error("master did not start with buffered msb");

   a_sck_idle: assert property (st.phase == spi_port_pkg::PH_IDLE |-> !sck_out)
      else $error("serial clock active while idle");

   a_done_set: assert property (is_master && st.phase == spi_port_pkg::PH_SHIFT && st.sck
                                && st.divcnt == st.clkdiv && st.bitcnt == 3'h7 && !mode_fault
                                |=> st.ctrl.done && st.phase == spi_port_pkg::PH_IDLE)
      else $error("done flag not set after eighth bit");

   a_done_hold: assert property (st.ctrl.done && !wr_ctrl |=> st.ctrl.done)
      else $error("done flag dropped without a clear");

   a_rx_read: assert property (rd_in && addr_in == 8'h04 |=> rdata_out == $past(st.rxbuf))
      else $error("data register read wrong");

   a_tx_buffer: assert property (wr_data |=> st.txbuf == $past(wdata_in) && st.tx_full)
      else $error("data write not buffered");

endmodule

// ### testbench/spi_far_end.sv
// spi_far_end.sv - behavioural serial slave standing on the far side of the port
// assumes mode 0 framing: sample on the rising serial clock, change after the falling one
`timescale 1ns/1ps

module spi_far_end (
   input  wire logic       clk_in,
   input  wire logic       sck_in,
   input  wire logic       mosi_in,
   input  wire logic       sel_n_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            miso_out,
   output logic [7:0]      rx_byte_out
);
   logic [7:0] shreg;
   logic [2:0] cnt;
   logic       idle_pat = 1'h0;

   initial rx_byte_out = 8'h00;

   ////////////////////////////////////////////////////////////////
   // a falling select frames a new byte
   always @(negedge sel_n_in) begin
      shreg = tx_byte_in;
      cnt   = 3'h0;
   end

   // capture on the rising clock, most significant bit first
   always @(posedge sck_in) begin
      if (!sel_n_in) begin
         rx_byte_out = {rx_byte_out[6:0], mosi_in};
         cnt         = cnt + 3'h1;
      end
   end

   // shift after the falling clock, reload at a byte boundary
   always @(negedge sck_in) begin
      if (!sel_n_in) begin
         shreg = (cnt == 3'h0) ? tx_byte_in : {shreg[6:0], 1'h0};
      end
   end

   // a released line shows a changing pattern, never the last bit
   always @(posedge clk_in) idle_pat <= ~idle_pat;
   assign miso_out = sel_n_in ? idle_pat : shreg[7];
endmodule

// ### testbench/spi_port_bench.sv
// spi_port_bench.sv - self-checking bench for the serial port
// assumes spi_port and spi_far_end are compiled alongside; pins resolved here from enables
`timescale 1ns/1ps
`include "spi_port_params.svh"

module spi_port_bench;
   logic                   clk_in, srst_in, wr_in, rd_in;
   logic [`SPI_ADDR_W-1:0] addr_in;
   logic [7:0]             wdata_in, rdata_out, far_tx, far_rx, rd_val, rx_got;
   logic                   sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
   logic                   nss_out, nss_oe_out, nss_routed_out, far_miso;
   logic                   sck_tb, mosi_tb, nss_tb, mosi_busy, tog, far_on;
   logic                   sck_w, mosi_w, miso_w, nss_w;
   int                     fail_count, num_checks;
   int unsigned            seed_val;
   logic [7:0]             reset_addr [4] = '{`SPI_OFS_CONTROL, `SPI_OFS_DATA, `SPI_OFS_CLKDIV, 8'h0c};
   logic [7:0]             reset_val  [4] = '{8'h00, `SPI_BYTE_RESET, `SPI_CLKDIV_RESET, 8'h00};

   // each pin follows whoever enables it; an idle bench data line keeps changing
   assign sck_w  = sck_oe_out  ? sck_out  : sck_tb;
   assign mosi_w = mosi_oe_out ? mosi_out : (mosi_busy ? mosi_tb : tog);
   assign miso_w = miso_oe_out ? miso_out : far_miso;
   assign nss_w  = nss_oe_out  ? nss_out  : nss_tb;

   spi_port u_dut (
      .clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .sck_in(sck_w), .sck_out(sck_out), .sck_oe_out(sck_oe_out),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
      .miso_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
      .nss_in(nss_w), .nss_out(nss_out), .nss_oe_out(nss_oe_out), .nss_routed_out(nss_routed_out)
   );

   spi_far_end u_far (
      .clk_in(clk_in), .sck_in(sck_w), .mosi_in(mosi_w), .sel_n_in(nss_w | ~far_on),
      .tx_byte_in(far_tx), .miso_out(far_miso), .rx_byte_out(far_rx)
   );

   initial begin
      clk_in = 1'h0;
      forever #10 clk_in = ~clk_in;
   end
   always @(posedge clk_in) tog <= ~tog;

   ////////////////////////////////////////////////////////////////
   // comparison, bus cycles and expectations
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_in <= 1'h1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clk_in);
      wr_in <= 1'h0;
      #1;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      rd_in <= 1'h1;
      addr_in <= a;
      @(posedge clk_in);
      rd_in <= 1'h0;
      #1 d = rdata_out;
   endtask

   function automatic logic [7:0] ctl(input logic mst, input logic [1:0] mode, input logic en);
      return {1'h0, mst, 2'h0, mode, 1'h0, en};
   endfunction

   // control write, then the select pin's routing, drive and level
   task automatic set_ctl(input logic [7:0] v);
      reg_wr(`SPI_OFS_CONTROL, v);
      check({5'h00, nss_routed_out, nss_oe_out, nss_oe_out & nss_out},
            {5'h00, v[3] | v[2], v[3] & v[0], v[3] & v[0] & v[2]}, "select pin");
   endtask

   task automatic wait_done();
      for (int n = 0; n < 400; n++) begin
         reg_rd(`SPI_OFS_CONTROL, rd_val);
         if (rd_val[`SPI_CTL_DONE] === 1'h1) return;
      end
      fail_count++;
      $display("CHECK FAILED at %0t: transfer never finished", $time);
      give_verdict();
   endtask

   // one master byte against the far end; hi then lo frames it with a select fall
   task automatic master_xfer(input logic [7:0] hi, input logic [7:0] lo, input logic [7:0] b);
      far_tx <= 8'($urandom);
      nss_tb <= 1'h1;
      set_ctl(hi);
      nss_tb <= 1'h0;
      set_ctl(lo);
      reg_rd(`SPI_OFS_CONTROL, rd_val);
      check(rd_val & 8'h80, 8'h00, "done cleared by write");
      check({5'h00, sck_oe_out, mosi_oe_out, miso_oe_out}, 8'h06, "master drives");
      reg_wr(`SPI_OFS_DATA, b);
      repeat (2) @(posedge clk_in);
      #1 check({6'h00, mosi_out, sck_out}, {6'h00, b[7], 1'h0}, "first bit out");
      wait_done();
      check(far_rx, b, "byte at far end");
      reg_rd(`SPI_OFS_DATA, rd_val);
      check(rd_val, far_tx, "byte received");
      repeat (20) @(posedge clk_in);
      reg_rd(`SPI_OFS_CONTROL, rd_val);
      check(rd_val & 8'hc0, 8'hc0, "done held");
   endtask

   // the bench as master at 160 ns per bit, sampling the reply before each rise
   task automatic sbyte(input logic [7:0] tx, output logic [7:0] rx);
      mosi_busy <= 1'h1;
      for (int i = 7; i >= 0; i--) begin
         @(posedge clk_in);
         mosi_tb <= tx[i];
         repeat (2) @(posedge clk_in);
         @(negedge clk_in) rx[i] = miso_w;
         @(posedge clk_in);
         sck_tb <= 1'h1;
         repeat (4) @(posedge clk_in);
         sck_tb <= 1'h0;
      end
      @(posedge clk_in);
      mosi_busy <= 1'h0;
   endtask

   task automatic slave_xfer(input logic [7:0] tx, input logic [7:0] rx_exp);
      reg_wr(`SPI_OFS_DATA, tx);
      nss_tb <= 1'h0;
      repeat (8) @(posedge clk_in);
      check({7'h00, miso_oe_out}, 8'h01, "selected slave drives");
      sbyte(rx_exp, rx_got);
      repeat (8) @(posedge clk_in);
      check(rx_got, tx, "slave reply");
      reg_rd(`SPI_OFS_CONTROL, rd_val);
      check(rd_val & 8'h80, 8'h80, "slave done");
      reg_rd(`SPI_OFS_DATA, rd_val);
      check(rd_val, rx_exp, "slave receive");
   endtask

   ////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed_val = $urandom(32'ha66f_7f37);
      fail_count = 0;
      num_checks = 0;
      {srst_in, wr_in, rd_in, addr_in, wdata_in} = {3'h4, 8'h00, 8'h00};
      {sck_tb, mosi_tb, nss_tb, mosi_busy, far_on, far_tx, tog} = {5'h01, 8'h00, 1'h0};
      repeat (3) @(posedge clk_in);
      srst_in <= 1'h0;
      for (int i = 0; i < 4; i++) begin
         reg_rd(reset_addr[i], rd_val);
         check(rd_val, reset_val[i], "reset value");
      end
      check({4'h0, sck_oe_out, mosi_oe_out, miso_oe_out, nss_oe_out}, 8'h00, "idle pins");
      reg_wr(8'h0c, 8'hff);
      reg_rd(`SPI_OFS_CLKDIV, rd_val);
      check(rd_val, `SPI_CLKDIV_RESET, "unmapped write ignored");
      for (int i = 0; i < 8; i++) begin
         reg_wr(`SPI_OFS_CLKDIV, 8'(3 + $urandom_range(4)));
         rx_got = (i == 0) ? 8'h80 : (i == 4) ? 8'h01 : 8'($urandom);
         if (i < 4) master_xfer(ctl(1'h1, 2'h0, 1'h1), ctl(1'h1, 2'h0, 1'h1), rx_got);
         else master_xfer(ctl(1'h1, 2'h3, 1'h1), ctl(1'h1, 2'h2, 1'h1), rx_got);
      end
      // a second master pulls select low
      nss_tb <= 1'h1;
      set_ctl(ctl(1'h1, 2'h1, 1'h1));
      repeat (4) @(posedge clk_in);
      nss_tb <= 1'h0;
      repeat (8) @(posedge clk_in);
      reg_rd(`SPI_OFS_CONTROL, rd_val);
      check(rd_val & 8'h60, 8'h20, "master dropped, fault set");
      check({6'h00, sck_oe_out, mosi_oe_out}, 8'h00, "master lines released");
      // slave roles, the far end stays unselected
      far_on <= 1'h0;
      set_ctl(8'h00);
      check({7'h00, miso_oe_out}, 8'h00, "disabled releases");
      nss_tb <= 1'h1;
      set_ctl(ctl(1'h0, 2'h1, 1'h1));
      check({7'h00, miso_oe_out}, 8'h00, "unselected releases");
      sbyte(8'hff, rx_got);
      reg_rd(`SPI_OFS_CONTROL, rd_val);
      check(rd_val & 8'h80, 8'h00, "clock ignored");
      slave_xfer(8'($urandom), 8'($urandom));
      nss_tb <= 1'h1;
      set_ctl(ctl(1'h0, 2'h0, 1'h1));
      check({5'h00, sck_oe_out, mosi_oe_out, miso_oe_out}, 8'h01, "three-line slave");
      slave_xfer(8'h81, 8'($urandom));
      give_verdict();
   end
endmodule
